// File: inband_mgmt_pkg.sv
/*
  Package for the in-band management status, indicator and pad drive register bank.
  Assumes one system clock and a synchronous active-low reset in every user.
*/
package inband_mgmt_pkg;
  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [15:0] PAD_DRIVE_OFS = 16'h010d;
  localparam logic [15:0] FRAME_STATUS_OFS = 16'h0110;
  localparam logic [15:0] IND_SELECT_OFS = 16'h0120;
  localparam logic [15:0] IND_LEVEL_OFS = 16'h0124;
  // ****************************************
  // Field positions and values
  // ****************************************
  localparam int GOOD_BIT = 31;
  localparam int RESP_BIT = 30;
  localparam int EXEC_BIT = 29;
  localparam int MAC_ERR_BIT = 14;
  localparam int FMT_ERR_BIT = 13;
  localparam int CODE_ERR_BIT = 12;
  localparam int CMD_ERR_BIT = 11;
  localparam int SIZE_ERR_BIT = 10;
  localparam int LOC_W = 7;
  localparam int IND_PINS = 10;
  localparam logic [15:0] ACCESS_FORMAT_OK = 16'h9800;
  localparam logic [15:0] ACCESS_CODE_A = 16'h0001;
  localparam logic [15:0] ACCESS_CODE_B = 16'h0002;
  localparam logic [8:0] MAX_FRAME_BYTES = 9'h140;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [2:0] HS_DRIVE_RST = 3'h6;
  localparam logic [2:0] LS_DRIVE_RST = 3'h2;
  localparam logic [9:0] IND_RST = 10'h000;
  // ****************************************
  // Frame outcome report from the frame engine
  // ****************************************
  typedef struct packed {
    logic frame_done;       // One-cycle pulse at end of frame check
    logic tag_match;        // Tag field of this frame matches
    logic addr_match;       // Destination equals switch address
    logic [15:0] fmt;       // Access format field
    logic [15:0] code;      // Access code field
    logic cmd_bad;          // Unknown command code seen
    logic [6:0] cmd_loc;    // Where the bad command sat
    logic [8:0] length;     // Frame bytes incl. pad and FCS, saturating
  } frame_report_s;
  // Register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } reg_req_s;
endpackage : inband_mgmt_pkg

// File: indicator_mux.sv
/*
  Per-pin choice between link LED and software output level.
  Assumes select and level come from registers in the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module indicator_mux
  import inband_mgmt_pkg::*;
#(
  parameter int PINS = IND_PINS
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [PINS-1:0] link_led_in,
  input wire logic [PINS-1:0] select_in,
  input wire logic [PINS-1:0] level_in,
  output logic [PINS-1:0] indicator_pin_out
);
  logic [PINS-1:0] pin_r;   // Registered pin levels
  logic [PINS-1:0] pin_nxt; // Next pin levels
  // ****************************************
  // Per-pin selection
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < PINS; i++) begin : g_pin
      // One means software output, zero means LED
      always_comb begin
        pin_nxt[i] = select_in[i] ? level_in[i] : link_led_in[i];
      end
    end
  endgenerate
  // Register so pins never glitch on select change
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pin_r <= '0;
    end else begin
      pin_r <= pin_nxt;
    end
  end
  assign indicator_pin_out = pin_r;
  // Each pin shows the level chosen one cycle earlier
  a_pin_follows: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    ##1 pin_r == $past(select_in & level_in | ~select_in & link_led_in))
    else $error("indicator pin level wrong");
endmodule : indicator_mux
`default_nettype wire

// File: inband_mgmt_status_led_gpo.sv
/*
  Global I/O control register bank: in-band frame status, indicator pin
  function and level, pad drive codes.
  Assumes a frame engine that reports each checked frame as one pulse with
  its fields, and a register port in the system clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
// Function
// - Good frame sets status bit 31
// - Response sent sets status bit 30
// - All commands executed sets bit 29
// - Tag-matching new frame clears sticky flags except good bit 31
// - Address mismatch bit 14 only when enabled
// - Format not 9800 sets bit 13
// - Access code not 1 or 2 sets bit 12
// - Unknown command sets bit 11
// - Over 320 bytes sets bit 10, no response
// - Bits 6:0 give bad command location
// - Select bit chooses LED or output
// - Output field drives selected pins
// - Drive codes stored, reset 110b and 10b
// - Enabled address match discards mismatching frames
module inband_mgmt_status_led_gpo
  import inband_mgmt_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire reg_req_s reg_req_in,
  output logic [31:0] reg_rdata_out,
  input wire logic inband_addr_match_enable_in,
  input wire frame_report_s report_in,
  input wire logic resp_sent_in,
  input wire logic exec_done_in,
  output logic frame_discard_out,
  output logic resp_suppress_out,
  input wire logic [IND_PINS-1:0] link_led_in,
  output logic [IND_PINS-1:0] indicator_pin_out
);
  // ****************************************
  // Register state
  // ****************************************
  logic [31:0] status_r, status_nxt;   // Frame status word
  logic [6:0] drive_r, drive_nxt;      // Pad drive codes, bit 3 kept
  logic drive7_r, drive7_nxt;          // Reserved writable bit 7
  logic [IND_PINS-1:0] sel_r, sel_nxt; // Pin function select
  logic [IND_PINS-1:0] lvl_r, lvl_nxt; // Pin output level
  logic [31:0] rdata_r, rdata_nxt;     // Registered read data
  logic discard_r, discard_nxt;        // Frame dropped on address
  logic suppress_r, suppress_nxt;      // Response withheld
  logic mac_bad;                       // Address check failed
  logic fmt_bad;                       // Format check failed
  logic code_bad;                      // Code check failed
  logic too_long;                      // Length over limit
  // ****************************************
  // Frame checks
  // ****************************************
  always_comb begin
    mac_bad = inband_addr_match_enable_in && !report_in.addr_match;
    fmt_bad = report_in.fmt != ACCESS_FORMAT_OK;
    code_bad = report_in.code != ACCESS_CODE_A && report_in.code != ACCESS_CODE_B;
    too_long = report_in.length > MAX_FRAME_BYTES;
  end
  // ****************************************
  // Status update; events win over the frame clear
  // ****************************************
  always_comb begin
    status_nxt = status_r;
    discard_nxt = 1'b0;
    suppress_nxt = 1'b0;
    if (report_in.frame_done) begin
      // New tag-matching frame clears the old outcome, except good bit 31, first
      if (report_in.tag_match) begin
        status_nxt[RESP_BIT] = 1'b0;
        status_nxt[EXEC_BIT] = 1'b0;
        status_nxt[MAC_ERR_BIT:SIZE_ERR_BIT] = '0;
        status_nxt[LOC_W-1:0] = '0;
      end
      // Dropped frame: only the address error is recorded
      if (mac_bad) begin
        status_nxt[MAC_ERR_BIT] = 1'b1;
        discard_nxt = 1'b1;
      end else begin
        // Accepted frame: every content check reports on its own
        if (fmt_bad) begin
          status_nxt[FMT_ERR_BIT] = 1'b1;
        end
        if (code_bad) begin
          status_nxt[CODE_ERR_BIT] = 1'b1;
        end
        if (report_in.cmd_bad) begin
          status_nxt[CMD_ERR_BIT] = 1'b1;
          status_nxt[LOC_W-1:0] = report_in.cmd_loc;
        end
        // Oversize frames are never answered
        if (too_long) begin
          status_nxt[SIZE_ERR_BIT] = 1'b1;
          suppress_nxt = 1'b1;
        end
        if (!fmt_bad && !code_bad && !report_in.cmd_bad && !too_long) begin
          status_nxt[GOOD_BIT] = 1'b1;
        end
      end
    end
    // Late engine events set after any clear in the same cycle
    if (resp_sent_in) begin
      status_nxt[RESP_BIT] = 1'b1;
    end
    if (exec_done_in) begin
      status_nxt[EXEC_BIT] = 1'b1;
    end
  end
  // ****************************************
  // Register writes and reads
  // ****************************************
  always_comb begin
    drive_nxt = drive_r;
    drive7_nxt = drive7_r;
    sel_nxt = sel_r;
    lvl_nxt = lvl_r;
    rdata_nxt = rdata_r;
    // Status word has no write path at all
    if (reg_req_in.wr) begin
      if (reg_req_in.addr == PAD_DRIVE_OFS) begin
        drive_nxt = reg_req_in.wdata[6:0];
        drive7_nxt = reg_req_in.wdata[7];
      end else if (reg_req_in.addr == IND_SELECT_OFS) begin
        sel_nxt = reg_req_in.wdata[IND_PINS-1:0];
      end else if (reg_req_in.addr == IND_LEVEL_OFS) begin
        lvl_nxt = reg_req_in.wdata[IND_PINS-1:0];
      end
    end
    if (reg_req_in.rd) begin
      if (reg_req_in.addr == PAD_DRIVE_OFS) begin
        rdata_nxt = {24'h000000, drive7_r, drive_r};
      end else if (reg_req_in.addr == FRAME_STATUS_OFS) begin
        rdata_nxt = status_r;
      end else if (reg_req_in.addr == IND_SELECT_OFS) begin
        rdata_nxt = {22'h000000, sel_r};
      end else if (reg_req_in.addr == IND_LEVEL_OFS) begin
        rdata_nxt = {22'h000000, lvl_r};
      end else begin
        // Unmapped reads return zero
        rdata_nxt = 32'h00000000;
      end
    end
  end
  // Registers only
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      status_r <= 32'h00000000;
      drive_r <= {HS_DRIVE_RST, 1'b0, LS_DRIVE_RST};
      drive7_r <= 1'b0;
      sel_r <= IND_RST;
      lvl_r <= IND_RST;
      rdata_r <= 32'h00000000;
      discard_r <= 1'b0;
      suppress_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      drive_r <= drive_nxt;
      drive7_r <= drive7_nxt;
      sel_r <= sel_nxt;
      lvl_r <= lvl_nxt;
      rdata_r <= rdata_nxt;
      discard_r <= discard_nxt;
      suppress_r <= suppress_nxt;
    end
  end
  assign reg_rdata_out = rdata_r;
  assign frame_discard_out = discard_r;
  assign resp_suppress_out = suppress_r;
  // ****************************************
  // Indicator pins
  // ****************************************
  indicator_mux #(.PINS(IND_PINS)) u_mux (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .link_led_in(link_led_in),
    .select_in(sel_r),
    .level_in(lvl_r),
    .indicator_pin_out(indicator_pin_out)
  );
  // ****************************************
  // Checks
  // ****************************************
  // All checks share the register clock and reset
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_good_set: assert property (report_in.frame_done && !mac_bad && !fmt_bad && !code_bad
    && !report_in.cmd_bad && !too_long |=> status_r[GOOD_BIT]) else $error("good flag missing");
  a_resp_set: assert property (resp_sent_in |=> status_r[RESP_BIT])
    else $error("response flag missing");
  a_exec_set: assert property (exec_done_in |=> status_r[EXEC_BIT])
    else $error("exec flag missing");
  a_tag_clear: assert property (report_in.frame_done && report_in.tag_match && !exec_done_in
    |=> !status_r[EXEC_BIT]) else $error("exec flag not cleared");
  a_mac_gate: assert property (!inband_addr_match_enable_in |=>
    !$rose(status_r[MAC_ERR_BIT])) else $error("mac error while disabled");
  a_fmt_err: assert property (report_in.frame_done && !mac_bad && fmt_bad
    |=> status_r[FMT_ERR_BIT]) else $error("format error missing");
  a_code_err: assert property (report_in.frame_done && !mac_bad && code_bad
    |=> status_r[CODE_ERR_BIT]) else $error("code error missing");
  a_cmd_loc: assert property (report_in.frame_done && !mac_bad && report_in.cmd_bad
    |=> status_r[CMD_ERR_BIT] && status_r[6:0] == $past(report_in.cmd_loc))
    else $error("command error or location wrong");
  a_size_err: assert property (report_in.frame_done && !mac_bad && too_long
    |=> status_r[SIZE_ERR_BIT] && resp_suppress_out) else $error("oversize not flagged");
  a_discard: assert property (report_in.frame_done && mac_bad |=> frame_discard_out)
    else $error("mismatch not discarded");
  a_status_ro: assert property (!report_in.frame_done && !resp_sent_in && !exec_done_in
    |=> $stable(status_r)) else $error("status changed without event");
  c_good: cover property (report_in.frame_done ##1 status_r[GOOD_BIT]);
  c_cmd: cover property (status_r[CMD_ERR_BIT] && status_r[6:0] != 7'h00);
  c_gpo: cover property (sel_r != 10'h000 ##2 indicator_pin_out != 10'h000);
  a_good_sticky: assert property (status_r[GOOD_BIT] |=> status_r[GOOD_BIT])
    else $error("good flag lost");
  a_resp_gate: assert property (report_in.frame_done && !too_long |=> !resp_suppress_out)
    else $error("response withheld without oversize");
  c_drop: cover property (report_in.frame_done && mac_bad ##1 frame_discard_out);
endmodule : inband_mgmt_status_led_gpo
`default_nettype wire

// File: frame_host.sv
/* Far-side frame engine model: hands checked-frame reports and event pulses.
   Assumes the bench calls its tasks; inputs change on the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module frame_host
  import inband_mgmt_pkg::*;
(
  output var frame_report_s report_out,
  output logic resp_sent_out,
  output logic exec_done_out,
  input wire logic core_clk_in
);
  // ****************************************
  // Report and event drivers
  // ****************************************
  initial begin
    report_out = '0;
    resp_sent_out = 1'b0;
    exec_done_out = 1'b0;
  end
  // One-cycle report; idle fields inverted so stale data never looks valid
  task automatic send(input frame_report_s r);
    frame_report_s idle;
    idle = ~r;
    idle.frame_done = 1'b0;
    r.frame_done = 1'b1;
    @(negedge core_clk_in);
    report_out = r;
    @(negedge core_clk_in);
    report_out = idle;
  endtask : send
  // One-cycle response or execution event
  task automatic pulse(input logic rs, input logic ex);
    @(negedge core_clk_in);
    resp_sent_out = rs;
    exec_done_out = ex;
    @(negedge core_clk_in);
    resp_sent_out = 1'b0;
    exec_done_out = 1'b0;
  endtask : pulse
endmodule : frame_host
`default_nettype wire

// File: inband_mgmt_status_led_gpo_test.sv
/* Self-checking bench for the status, indicator and drive register bank.
   Assumes the frame_host model and a 20 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module inband_mgmt_status_led_gpo_test;
  import inband_mgmt_pkg::*;
  // ****************************************
  // Signals and counters
  // ****************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  reg_req_s req = '0;
  logic [31:0] rdata;
  logic en = 1'b0;
  frame_report_s rep;
  logic rs, ex, disc, supp;
  logic [9:0] led = '0;
  logic [9:0] pins;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  integer seed = 48301;
  logic [31:0] st, d, v;
  frame_report_s f;
  always #25 clk = ~clk;
  frame_host i_host (.report_out(rep), .resp_sent_out(rs), .exec_done_out(ex),
    .core_clk_in(clk));
  inband_mgmt_status_led_gpo i_dut (.core_clk_in(clk), .rst_n_in(rst_n),
    .reg_req_in(req), .reg_rdata_out(rdata), .inband_addr_match_enable_in(en),
    .report_in(rep), .resp_sent_in(rs), .exec_done_in(ex), .frame_discard_out(disc),
    .resp_suppress_out(supp), .link_led_in(led), .indicator_pin_out(pins));
  // ****************************************
  // Tasks and expectation
  // ****************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // One-cycle register access; read data taken well after it lands
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] wd);
    @(negedge clk);
    req = '{wr: w, rd: !w, addr: a, wdata: wd};
    @(negedge clk);
    req = '0;
    @(negedge clk);
  endtask : acc
  // Status after one frame: tag clear first, mac drop skips other checks
  function automatic logic [31:0] nxt(logic [31:0] s, frame_report_s r, logic e);
    logic ok;
    if (r.tag_match) s = s & 32'h8000_0000;
    if (e && !r.addr_match) begin
      s[MAC_ERR_BIT] = 1'b1;
      return s;
    end
    ok = 1'b1;
    if (r.fmt !== ACCESS_FORMAT_OK) {s[FMT_ERR_BIT], ok} = 2'b10;
    if (r.code !== ACCESS_CODE_A && r.code !== ACCESS_CODE_B) {s[CODE_ERR_BIT], ok} = 2'b10;
    if (r.cmd_bad) {s[CMD_ERR_BIT], s[6:0], ok} = {1'b1, r.cmd_loc, 1'b0};
    if (r.length > MAX_FRAME_BYTES) {s[SIZE_ERR_BIT], ok} = 2'b10;
    if (ok) s[GOOD_BIT] = 1'b1;
    return s;
  endfunction : nxt
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    // Reset values of every mapped register and of the pins
    acc(0, PAD_DRIVE_OFS, 0);
    check(rdata, 32'h62);
    acc(0, FRAME_STATUS_OFS, 0);
    check(rdata, 0);
    acc(0, IND_SELECT_OFS, 0);
    check(rdata, 0);
    acc(0, IND_LEVEL_OFS, 0);
    check(rdata, 0);
    check(pins, 0);
    st = 32'h0;
    for (int i = 0; i < 40; i++) begin
      f = '0;
      f.tag_match = (i < 9) || $random(seed) % 4 != 0;
      f.addr_match = i != 8 && (i < 9 || $random(seed) % 4 != 0);
      f.fmt = (i == 2 || (i > 8 && $random(seed) % 4 == 0)) ? $random(seed) : ACCESS_FORMAT_OK;
      f.code = (i == 3) ? 16'h0003 : (i > 8 && $random(seed) % 4 == 0) ? $random(seed) : i % 2 + 1;
      f.cmd_bad = i == 4 || (i > 8 && $random(seed) % 4 == 0);
      f.cmd_loc = $random(seed);
      f.length = (i == 5) ? 9'h140 : (i == 6) ? 9'h141 : 9'h040 + $unsigned($random(seed)) % 300;
      en = i == 8 || (i > 8 && $random(seed) % 2 == 0);
      {d[0], d[1]} = (i < 9) ? 2'b11 : $random(seed);
      // Some frames meet their events in the same cycle: the set must win
      fork
        i_host.send(f);
        if (i % 4 == 1) i_host.pulse(d[0], d[1]);
      join
      check(disc, en && !f.addr_match);
      check(supp, !(en && !f.addr_match) && f.length > MAX_FRAME_BYTES);
      st = nxt(st, f, en);
      if (i % 4 != 1) i_host.pulse(d[0], d[1]);
      st[RESP_BIT] |= d[0];
      st[EXEC_BIT] |= d[1];
      acc(1, FRAME_STATUS_OFS, $random(seed));
      acc(0, FRAME_STATUS_OFS, 0);
      check(rdata, st);
    end
    // Address mismatch with the match check switched off
    en = 1'b0;
    f.addr_match = 1'b0;
    f.tag_match = 1'b1;
    i_host.send(f);
    check(disc, 0);
    st = nxt(st, f, en);
    acc(0, FRAME_STATUS_OFS, 0);
    check(rdata, st);
    acc(0, 16'h0114, 0);
    check(rdata, 0);
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      v = $random(seed);
      acc(1, PAD_DRIVE_OFS, d);
      acc(0, PAD_DRIVE_OFS, 0);
      check(rdata, d & 32'hff);
      acc(1, IND_SELECT_OFS, d);
      acc(0, IND_SELECT_OFS, 0);
      check(rdata, d & 32'h3ff);
      acc(1, IND_LEVEL_OFS, v);
      acc(0, IND_LEVEL_OFS, 0);
      check(rdata, v & 32'h3ff);
      led = $random(seed);
      repeat (3) @(negedge clk);
      check(pins, (d[9:0] & v[9:0]) | (~d[9:0] & led));
    end
    end_of_test();
  end
endmodule : inband_mgmt_status_led_gpo_test
`default_nettype wire
